// ### hdl/swrc_counter.sv
/*
  swrc_counter: watchdog up-counter with clear, hold and increment.
  Assumes: one clock; clear has priority over increment.
*/
`timescale 1ns/100ps
`default_nettype none

module swrc_counter #(
  parameter int unsigned WIDTH = swrc_pkg::COUNT_W
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // control
  input  wire logic             clear_i,
  input  wire logic             inc_i,
  // state
  output logic [WIDTH-1:0]      count_o
);

  logic [WIDTH-1:0] count_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else if (clear_i) begin
      count_q <= '0;                                // [RULE17]
    end else if (inc_i) begin
      count_q <= count_q + WIDTH'(1);               // [RULE17]
    end
  end

  assign count_o = count_q;

endmodule : swrc_counter

`default_nettype wire

// ### hdl/swrc_pkg.sv
/*
  swrc_pkg: constants and types for the system watchdog and reset control block.
  Assumes: used by swrc_top and swrc_counter; every use is written swrc_pkg::name.
*/
package swrc_pkg;

  // register byte addresses on the avalon slave
  localparam logic [7:0] ADDR_RESET_SOURCE    = 8'h00;
  localparam logic [7:0] ADDR_OPTIONS         = 8'h04;
  localparam logic [7:0] ADDR_OPTIONS_TWO     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS      = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLEAR       = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE      = 8'h14;
  localparam logic [7:0] ADDR_WATCHDOG_COUNT  = 8'h18;

  // system options register fields
  localparam int unsigned OPT_ENABLE_BIT      = 0;
  localparam int unsigned OPT_TIMEOUT_BIT     = 1;
  localparam int unsigned OPT_LOCK_BIT        = 7;
  // system options register two fields
  localparam int unsigned OPT2_CLKSEL_BIT     = 0;
  localparam int unsigned OPT2_LOCK_BIT       = 7;

  // reset values of the watchdog settings
  localparam logic        ENABLE_RESET        = 1'b1;
  localparam logic        TIMEOUT_RESET       = 1'b1;
  localparam logic        CLKSEL_RESET        = 1'b1;

  // overflow exponents: clock select / timeout select
  localparam int unsigned EXP_SLOW_SHORT      = 5;
  localparam int unsigned EXP_SLOW_LONG       = 8;
  localparam int unsigned EXP_BUS_SHORT       = 13;
  localparam int unsigned EXP_BUS_LONG        = 18;
  localparam int unsigned COUNT_W             = EXP_BUS_LONG + 1;

  // interrupt status bits
  localparam int unsigned IRQ_W               = 3;
  localparam int unsigned IRQ_TIMEOUT_BIT     = 0;
  localparam int unsigned IRQ_SERVICE_BIT     = 1;
  localparam int unsigned IRQ_LOCKED_WR_BIT   = 2;

  // cycles for which a system reset is held
  localparam int unsigned RESET_HOLD_CYCLES   = 16;

  // reset source register layout, one bit per cause
  typedef struct packed {
    logic power_on;      // bit 7
    logic reset_pin;     // bit 6
    logic watchdog;      // bit 5
    logic illegal_op;    // bit 4
    logic illegal_addr;  // bit 3
    logic clock_loss;    // bit 2
    logic low_voltage;   // bit 1
    logic unused0;       // bit 0
  } swrc_source_t;

  localparam swrc_source_t SOURCE_POR = '{power_on: 1'b1, default: 1'b0};

  // reset causes coming from the rest of the chip
  typedef struct packed {
    logic low_voltage_detect;
    logic reset_pin;
    logic illegal_op;
    logic illegal_addr;
    logic clock_loss;
    logic debug_force;
  } swrc_cause_t;

endpackage : swrc_pkg

// ### hdl/swrc_top.sv
/*
  swrc_top: watchdog with reset-source bookkeeping, avalon-mm slave with waitrequest.
  Assumes: 125 MHz clk_i; rst_n_i is power-on reset; cause, stop and debug inputs
  come from logic on clk_i; slow_clk_i is the asynchronous ~1 kHz clock.
*/
// Overview of operation
// [RULE1] every reset sets the watchdog enable bit, watchdog active by default
// [RULE2] clearing the enable bit stops the watchdog from causing any reset
// [RULE3] any write to the reset source address clears the watchdog counter
// [RULE4] that write leaves reset source contents unchanged, only services the watchdog; swrc_top also sets the service interrupt status bit
// [RULE5] clock select 0 picks the slow ~1 kHz clock, 1 picks the bus clock
// [RULE6] slow clock: timeout select 0 overflows at 2^5, 1 at 2^8 clocks
// [RULE7] bus clock: timeout select 0 overflows at 2^13, 1 at 2^18 cycles
// [RULE8] counter reaching overflow unserviced generates a system reset
// [RULE9] both option registers take only their first write after reset
// [RULE10] the first write to either option register also clears the counter
// [RULE11] in background debug mode the counter holds its value
// [RULE12] bus clock: counter freezes in stop mode, resumes from held value
// [RULE13] slow clock: counter cleared on stop entry, counts from zero afterwards
// [RULE14] reset source register records latest cause, one bit each, debug has none
// [RULE15] during reset peripherals disabled, pins high-impedance inputs, pulls off; swrc_top drives no pull control output
// [RULE16] software must not service the watchdog inside an interrupt handler
// [RULE17] counter reaches 2^18, increments per selected clock, starts at zero
`timescale 1ns/100ps
`default_nettype none

module swrc_top #(
  parameter int unsigned RESET_HOLD = swrc_pkg::RESET_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // avalon-mm slave
  input  wire logic [7:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // interrupt
  output logic                      irq_o,
  // system state
  input  wire logic                 slow_clk_i,
  input  wire logic                 stop_mode_i,
  input  wire logic                 debug_mode_i,
  input  wire swrc_pkg::swrc_cause_t cause_i,
  // reset control
  output logic                      sys_reset_o,
  output logic                      periph_disable_o,
  output logic                      pins_hiz_input_o
);

  localparam int unsigned HOLD_W = $clog2(RESET_HOLD + 1);

  // bus access decode
  logic req_done;
  logic wr_done;
  logic wait_q;
  logic [31:0] rdata_q;

  assign req_done = (avs_read_i | avs_write_i) & ~wait_q;
  assign wr_done  = avs_write_i & ~wait_q;

  // one wait cycle, then the answer stands for one edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i | avs_write_i) & wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  logic wr_source;
  logic wr_opt;
  logic wr_opt2;
  logic wr_irq_clr;
  logic wr_irq_en;

  assign wr_source  = wr_done & (avs_address_i == swrc_pkg::ADDR_RESET_SOURCE);
  assign wr_opt     = wr_done & (avs_address_i == swrc_pkg::ADDR_OPTIONS);
  assign wr_opt2    = wr_done & (avs_address_i == swrc_pkg::ADDR_OPTIONS_TWO);
  assign wr_irq_clr = wr_done & (avs_address_i == swrc_pkg::ADDR_IRQ_CLEAR);
  assign wr_irq_en  = wr_done & (avs_address_i == swrc_pkg::ADDR_IRQ_ENABLE);

  // system reset sequencing
  logic [HOLD_W-1:0] hold_q;
  logic              in_reset_q;
  logic              wdog_expire;
  logic              any_cause;

  assign any_cause = wdog_expire | cause_i.low_voltage_detect | cause_i.reset_pin
                   | cause_i.illegal_op | cause_i.illegal_addr | cause_i.clock_loss
                   | cause_i.debug_force;

  // holds the whole chip in reset for RESET_HOLD cycles after any cause
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_q     <= HOLD_W'(RESET_HOLD);
      in_reset_q <= 1'b1;
    end else if (any_cause) begin
      hold_q     <= HOLD_W'(RESET_HOLD);
      in_reset_q <= 1'b1;                           // [RULE8]
    end else if (hold_q != '0) begin
      hold_q     <= hold_q - HOLD_W'(1);
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_reset_o      <= 1'b1;
      periph_disable_o <= 1'b1;
      pins_hiz_input_o <= 1'b1;
    end else begin
      sys_reset_o      <= any_cause | (hold_q != '0);
      periph_disable_o <= any_cause | (hold_q != '0); // [RULE15]
      pins_hiz_input_o <= any_cause | (hold_q != '0); // [RULE15]
    end
  end

  // reset source register; bus writes never reach it
  swrc_pkg::swrc_source_t source_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      source_q <= swrc_pkg::SOURCE_POR;             // [RULE14]
    end else if (any_cause) begin
      // latest cause replaces the old record; debug-forced reset leaves all clear
      source_q              <= '0;                  // [RULE14]
      source_q.reset_pin    <= cause_i.reset_pin;
      source_q.watchdog     <= wdog_expire;
      source_q.illegal_op   <= cause_i.illegal_op;
      source_q.illegal_addr <= cause_i.illegal_addr;
      source_q.clock_loss   <= cause_i.clock_loss;
      source_q.low_voltage  <= cause_i.low_voltage_detect;
    end
  end

  // write-once option registers, unlocked again only by a reset
  logic opt_enable_q;
  logic opt_timeout_q;
  logic opt_lock_q;
  logic opt2_clksel_q;
  logic opt2_lock_q;
  logic opt_first_wr;
  logic opt2_first_wr;

  assign opt_first_wr  = wr_opt & ~opt_lock_q;
  assign opt2_first_wr = wr_opt2 & ~opt2_lock_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt_enable_q  <= swrc_pkg::ENABLE_RESET;
      opt_timeout_q <= swrc_pkg::TIMEOUT_RESET;
      opt_lock_q    <= 1'b0;
    end else if (in_reset_q) begin
      opt_enable_q  <= swrc_pkg::ENABLE_RESET;      // [RULE1]
      opt_timeout_q <= swrc_pkg::TIMEOUT_RESET;
      opt_lock_q    <= 1'b0;
    end else if (opt_first_wr) begin
      opt_enable_q  <= avs_writedata_i[swrc_pkg::OPT_ENABLE_BIT];
      opt_timeout_q <= avs_writedata_i[swrc_pkg::OPT_TIMEOUT_BIT];
      opt_lock_q    <= 1'b1;                        // [RULE9]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt2_clksel_q <= swrc_pkg::CLKSEL_RESET;
      opt2_lock_q   <= 1'b0;
    end else if (in_reset_q) begin
      opt2_clksel_q <= swrc_pkg::CLKSEL_RESET;
      opt2_lock_q   <= 1'b0;
    end else if (opt2_first_wr) begin
      opt2_clksel_q <= avs_writedata_i[swrc_pkg::OPT2_CLKSEL_BIT];
      opt2_lock_q   <= 1'b1;                        // [RULE9]
    end
  end

  // slow clock: synchronise, then find rising edges
  logic slow_meta_q;
  logic slow_sync_q;
  logic slow_prev_q;
  logic slow_tick;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_meta_q <= 1'b0;
      slow_sync_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      slow_meta_q <= slow_clk_i;
      slow_sync_q <= slow_meta_q;
      slow_prev_q <= slow_sync_q;
    end
  end

  assign slow_tick = slow_sync_q & ~slow_prev_q;

  // stop span, stretched over the exit cycle; slow count stays zero through stop
  logic stop_prev_q;
  logic stop_span;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_prev_q <= 1'b0;
    end else begin
      stop_prev_q <= stop_mode_i;
    end
  end

  assign stop_span = stop_mode_i | stop_prev_q;

  // watchdog counter control
  logic                          service;
  logic                          cnt_clear;
  logic                          cnt_inc;
  logic                          sel_tick;
  logic [swrc_pkg::COUNT_W-1:0]  count;
  logic [swrc_pkg::COUNT_W-1:0]  limit;

  assign service = wr_source;                       // [RULE3] [RULE4]

  // stop freezes the bus clock source; the slow source is held at zero instead
  assign sel_tick = opt2_clksel_q ? ~stop_mode_i      // [RULE5] [RULE12]
                                  : slow_tick;        // [RULE5]

  assign cnt_clear = in_reset_q | service
                   | opt_first_wr | opt2_first_wr     // [RULE10]
                   | (~opt2_clksel_q & stop_span)     // [RULE13]
                   | wdog_expire;

  assign cnt_inc = opt_enable_q & ~debug_mode_i       // [RULE2] [RULE11]
                 & sel_tick & ~in_reset_q;

  always_comb begin
    unique case ({opt2_clksel_q, opt_timeout_q})
      2'b00:   limit = swrc_pkg::COUNT_W'(1) << swrc_pkg::EXP_SLOW_SHORT; // [RULE6]
      2'b01:   limit = swrc_pkg::COUNT_W'(1) << swrc_pkg::EXP_SLOW_LONG;  // [RULE6]
      2'b10:   limit = swrc_pkg::COUNT_W'(1) << swrc_pkg::EXP_BUS_SHORT;  // [RULE7]
      2'b11:   limit = swrc_pkg::COUNT_W'(1) << swrc_pkg::EXP_BUS_LONG;   // [RULE7]
    endcase
  end

  // a first write that lowers the limit also clears the count, so it never expires at once
  assign wdog_expire = opt_enable_q & ~in_reset_q & (count >= limit); // [RULE2] [RULE8]

  swrc_counter #(
    .WIDTH   (swrc_pkg::COUNT_W)
  ) u_counter (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (cnt_clear),
    .inc_i   (cnt_inc),
    .count_o (count)
  );

  // interrupt status; a set in the same cycle as its clear wins
  logic [swrc_pkg::IRQ_W-1:0] irq_status_q;
  logic [swrc_pkg::IRQ_W-1:0] irq_enable_q;
  logic [swrc_pkg::IRQ_W-1:0] irq_set;

  always_comb begin
    irq_set                              = '0;
    irq_set[swrc_pkg::IRQ_TIMEOUT_BIT]   = wdog_expire;
    irq_set[swrc_pkg::IRQ_SERVICE_BIT]   = service;
    irq_set[swrc_pkg::IRQ_LOCKED_WR_BIT] = (wr_opt & opt_lock_q) | (wr_opt2 & opt2_lock_q);
  end

  // only power-on and the clear register clear status, so a watchdog event survives its own reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status_q <= '0;
    end else if (wr_irq_clr) begin
      irq_status_q <= (irq_status_q & ~avs_writedata_i[swrc_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_enable_q <= '0;
    end else if (wr_irq_en) begin
      irq_enable_q <= avs_writedata_i[swrc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_q & irq_enable_q);
    end
  end

  // read data, latched in the wait cycle
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    unique case (avs_address_i)
      swrc_pkg::ADDR_RESET_SOURCE: begin
        rdata_d[7:0] = source_q;                    // [RULE4]
      end
      swrc_pkg::ADDR_OPTIONS: begin
        rdata_d[swrc_pkg::OPT_ENABLE_BIT]  = opt_enable_q;
        rdata_d[swrc_pkg::OPT_TIMEOUT_BIT] = opt_timeout_q;
        rdata_d[swrc_pkg::OPT_LOCK_BIT]    = opt_lock_q;
      end
      swrc_pkg::ADDR_OPTIONS_TWO: begin
        rdata_d[swrc_pkg::OPT2_CLKSEL_BIT] = opt2_clksel_q;
        rdata_d[swrc_pkg::OPT2_LOCK_BIT]   = opt2_lock_q;
      end
      swrc_pkg::ADDR_IRQ_STATUS: begin
        rdata_d[swrc_pkg::IRQ_W-1:0] = irq_status_q;
      end
      swrc_pkg::ADDR_IRQ_ENABLE: begin
        rdata_d[swrc_pkg::IRQ_W-1:0] = irq_enable_q;
      end
      swrc_pkg::ADDR_WATCHDOG_COUNT: begin
        rdata_d[swrc_pkg::COUNT_W-1:0] = count;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (avs_read_i & wait_q) begin
      rdata_q <= rdata_d;
    end else if (req_done) begin
      rdata_q <= '0;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

endmodule : swrc_top

`default_nettype wire

// ### testbench/swrc_monitor.sv
/* swrc_monitor: concurrent checks on the ports of swrc_top.
   Assumes: bound into swrc_top, RESET_HOLD handed on from the instance. */
`timescale 1ns/100ps
`default_nettype none
module swrc_monitor #(
  parameter int unsigned RESET_HOLD = swrc_pkg::RESET_HOLD_CYCLES
) (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  // bus
  input wire logic                  avs_read_i,
  input wire logic                  avs_write_i,
  input wire logic [7:0]            avs_address_i,
  input wire logic [31:0]           avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  // system
  input wire logic                  debug_mode_i,
  input wire swrc_pkg::swrc_cause_t cause_i,
  input wire logic                  sys_reset_o,
  input wire logic                  periph_disable_o,
  input wire logic                  pins_hiz_input_o
);
  logic [4:0] high_q;
  logic [4:0] dbg_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // saturating run lengths of reset and debug
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_q <= 5'h00;
      dbg_q  <= 5'h00;
    end else begin
      high_q <= !sys_reset_o ? 5'h00 : high_q + 5'(high_q != 5'h1f);
      dbg_q  <= !debug_mode_i ? 5'h00 : dbg_q + 5'(dbg_q != 5'h1f);
    end
  end

  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ans;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  property p_answer;
    s_req |=> s_ans;
  endproperty
  property p_idle_zero;
    avs_waitrequest_o |-> avs_readdata_o == 32'h0000_0000;
  endproperty
  property p_periph;
    periph_disable_o == sys_reset_o;
  endproperty
  property p_pins;
    pins_hiz_input_o == sys_reset_o;
  endproperty
  property p_cause;
    cause_i != '0 |-> ##[1:2] sys_reset_o;
  endproperty
  property p_hold;
    $fell(sys_reset_o) |-> high_q >= 5'(RESET_HOLD - 1);
  endproperty
  // a frozen counter cannot expire once debug has settled in
  property p_debug;
    $rose(sys_reset_o) |-> dbg_q < 5'h05 || ($past(cause_i) | $past(cause_i, 2)) != '0;
  endproperty
  property p_service;
    avs_write_i && !avs_waitrequest_o && avs_address_i == swrc_pkg::ADDR_RESET_SOURCE
      |=> (!$rose(sys_reset_o)) [*4];
  endproperty

  a_answer: assert property (p_answer) else $error("bus answer not one wait cycle");
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero at idle");
  a_periph: assert property (p_periph) else $error("peripheral disable off reset");
  a_pins: assert property (p_pins) else $error("pin hi-z control off reset");
  a_cause: assert property (p_cause) else $error("reset cause not followed by reset");
  a_hold: assert property (p_hold) else $error("system reset too short");
  a_debug: assert property (p_debug) else $error("watchdog expired in debug");
  a_service: assert property (p_service) else $error("reset right after service");
endmodule : swrc_monitor

bind swrc_top swrc_monitor #(.RESET_HOLD(RESET_HOLD)) i_mon (
  .clk_i, .rst_n_i, .avs_read_i, .avs_write_i, .avs_address_i, .avs_readdata_o,
  .avs_waitrequest_o, .debug_mode_i, .cause_i, .sys_reset_o, .periph_disable_o,
  .pins_hiz_input_o
);
`default_nettype wire

// ### testbench/swrc_top_test.sv
/* swrc_top_test: self-checking bench for swrc_top through its avalon slave.
   Assumes: swrc_pkg, swrc_top and swrc_monitor compiled first. */
`timescale 1ns/100ps
`default_nettype none
module swrc_top_test;
  // short hold keeps the many resets cheap
  localparam int unsigned HOLD = 2;
  logic                  clk_i, rst_n_i, slow_clk_i, stop_mode_i, debug_mode_i, irq_o;
  logic                  avs_read_i, avs_write_i, avs_waitrequest_o;
  logic                  sys_reset_o, periph_disable_o, pins_hiz_input_o;
  logic [7:0]            avs_address_i;
  logic [31:0]           avs_writedata_i, avs_readdata_o, rnd;
  logic [31:0]           exp_q[$];
  logic [7:0]            src_tab[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h40, 8'h02};
  swrc_pkg::swrc_cause_t cause_i;
  int                    n_fail, num_checks, cyc, n;

  swrc_top #(.RESET_HOLD(HOLD)) i_dut (
    .clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .irq_o, .slow_clk_i, .stop_mode_i,
    .debug_mode_i, .cause_i, .sys_reset_o, .periph_disable_o, .pins_hiz_input_o
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // stand-in oscillator, about 40 bus cycles a period, unrelated phase
  initial begin
    slow_clk_i = 1'b0;
    forever #161 slow_clk_i = ~slow_clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_writedata_i <= d;
    // no limit of its own; only the cycle timeout ends a wait that never sees waitrequest low
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic settle();
    int k;
    k = 0;
    while (sys_reset_o !== 1'b0 && k < 100) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 100) chk("settle", 32'h0000_0000, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
  endtask : settle

  task automatic expiry(input int lo, input int hi);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (sys_reset_o !== 1'b1 && n < 20000);
    chk("expiry window", 32'h0000_0001, 32'(n >= lo && n <= hi));
  endtask : expiry

  // read results are taken at the edge that sees waitrequest low
  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0)
        chk("read queue", 32'h0000_0000, 32'h0000_0001);
      else
        chk("readdata", exp_q.pop_front(), avs_readdata_o);
    end
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    rst_n_i = 1'b0;
    {avs_read_i, avs_write_i, stop_mode_i, debug_mode_i} = 4'h0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0000_0000;
    cause_i = '0;
    rnd = 32'h0000_0049;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    rd(swrc_pkg::ADDR_RESET_SOURCE, 32'h0000_0080);
    rd(swrc_pkg::ADDR_OPTIONS, 32'h0000_0003);
    rd(swrc_pkg::ADDR_OPTIONS_TWO, 32'h0000_0001);
    rd(8'h40, 32'h0000_0000);
    wr(swrc_pkg::ADDR_IRQ_ENABLE, 32'h0000_0007);
    rnd = xs(rnd);
    wr(swrc_pkg::ADDR_RESET_SOURCE, rnd);
    rd(swrc_pkg::ADDR_RESET_SOURCE, 32'h0000_0080);
    rd(swrc_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    @(negedge clk_i);
    chk("irq", 32'h0000_0001, 32'(irq_o));
    wr(swrc_pkg::ADDR_IRQ_CLEAR, 32'h0000_0007);
    repeat (2) @(negedge clk_i);
    chk("irq", 32'h0000_0000, 32'(irq_o));
    // lock with watchdog off, then a second write must bounce
    wr(swrc_pkg::ADDR_OPTIONS, 32'h0000_0000);
    rnd = xs(rnd);
    wr(swrc_pkg::ADDR_OPTIONS, rnd);
    rd(swrc_pkg::ADDR_OPTIONS, 32'h0000_0080);
    rd(swrc_pkg::ADDR_IRQ_STATUS, 32'h0000_0004);
    rd(swrc_pkg::ADDR_WATCHDOG_COUNT, 32'h0000_0000);
    repeat (9000) @(posedge clk_i);
    chk("sys_reset", 32'h0000_0000, 32'(sys_reset_o));
    // a short expiry pulse would have left the watchdog bit behind
    rd(swrc_pkg::ADDR_RESET_SOURCE, 32'h0000_0080);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      cause_i <= swrc_pkg::swrc_cause_t'(6'h01 << i);
      @(posedge clk_i);
      cause_i <= '0;
      @(negedge clk_i);
      chk("reset outs", 32'h0000_0007,
          32'({sys_reset_o, periph_disable_o, pins_hiz_input_o}));
      settle();
      rd(swrc_pkg::ADDR_RESET_SOURCE, 32'(src_tab[i]));
      rd(swrc_pkg::ADDR_OPTIONS, 32'h0000_0003);
    end
    wr(swrc_pkg::ADDR_IRQ_CLEAR, 32'h0000_0007);
    wr(swrc_pkg::ADDR_OPTIONS, 32'h0000_0001);
    wr(swrc_pkg::ADDR_OPTIONS_TWO, 32'h0000_0001);
    repeat (5000) @(posedge clk_i);
    // serviced from the main flow only, never from an interrupt handler
    wr(swrc_pkg::ADDR_RESET_SOURCE, rnd);
    // 6000 counted; stop and debug together would carry it past 8192
    repeat (6000) @(posedge clk_i);
    stop_mode_i <= 1'b1;
    repeat (1000) @(posedge clk_i);
    stop_mode_i <= 1'b0;
    debug_mode_i <= 1'b1;
    repeat (3000) @(posedge clk_i);
    debug_mode_i <= 1'b0;
    expiry(2188, 2202);
    settle();
    rd(swrc_pkg::ADDR_RESET_SOURCE, 32'h0000_0020);
    rd(swrc_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    wr(swrc_pkg::ADDR_OPTIONS, 32'h0000_0001);
    wr(swrc_pkg::ADDR_OPTIONS_TWO, 32'h0000_0000);
    // a stop longer than the short timeout; the count restarts at zero on exit
    repeat (800) @(posedge clk_i);
    stop_mode_i <= 1'b1;
    repeat (2000) @(posedge clk_i);
    stop_mode_i <= 1'b0;
    expiry(1240, 1300);
    settle();
    wr(swrc_pkg::ADDR_OPTIONS, 32'h0000_0003);
    wr(swrc_pkg::ADDR_OPTIONS_TWO, 32'h0000_0000);
    expiry(10240, 10320);
    settle();
    chk("pending reads", 32'h0000_0000, 32'(exp_q.size()));
    end_of_test();
  end
endmodule : swrc_top_test
`default_nettype wire
